// [hw/apfs_pkg.sv]
package apfs_pkg;

  // Register map (word offsets chosen for this block)
  localparam logic [3:0] ADDR_ENV2    = 4'h0;
  localparam logic [3:0] ADDR_OUTVAL  = 4'h1;
  localparam logic [3:0] ADDR_ONESHOT = 4'h2;
  localparam logic [3:0] ADDR_PINS    = 4'h3;
  localparam logic [3:0] ADDR_ENC     = 4'h4;

  localparam logic [31:0] ENV2_RESET  = 32'h0000_0000;
  localparam logic [7:0]  OUTVAL_RESET = 8'h00;

  // Field layout of the environment register
  localparam int FUNC_WIDTH    = 2;
  localparam int NUM_PINS      = 8;
  localparam int POL_ZERO_BIT  = 16;
  localparam int POL_ONE_BIT   = 17;
  localparam int ENC_FILT_BIT  = 18;
  localparam int ENV2_IMPL_MSB = 18;

  // Function codes
  localparam logic [1:0] FN_INPUT  = 2'h0;
  localparam logic [1:0] FN_OUTPUT = 2'h1;
  localparam logic [1:0] FN_FLAGLO = 2'h2;
  localparam logic [1:0] FN_FLAGHI = 2'h3;

  // Timing
  localparam int  CLOCK_HZ        = 50_000_000;
  localparam int  ONESHOT_MS      = 26;
  localparam int  ONESHOT_CYCLES  = (CLOCK_HZ / 1000) * ONESHOT_MS;
  localparam int  FILTER_CYCLES   = 3;

  typedef struct packed {
    logic accel;
    logic decel;
    logic constSpeed;
    logic [4:0] compareMatch;
  } apfs_motion_t;

  typedef struct packed {
    logic phaseA;
    logic phaseB;
    logic index;
  } apfs_encoder_t;

endpackage : apfs_pkg

// [hw/apfs_noise_filter.sv]
`timescale 1ns/10ps
// With enable high, passes a level only after it has held for FILT_CYCLES clocks; with enable low, follows the input
module apfs_noise_filter #(
  parameter int FILT_CYCLES = apfs_pkg::FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Data
  input  wire logic enable,
  input  wire logic rawIn,
  output logic      filtOut
);

  logic [1:0] holdCount;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      holdCount <= 2'h0;
      filtOut   <= 1'b0;
    end else if (!enable) begin
      holdCount <= 2'h0;
      filtOut   <= rawIn;
    end else if (rawIn == filtOut) begin
      holdCount <= 2'h0;
    end else if (holdCount == 2'(FILT_CYCLES - 1)) begin
      // Pulses shorter than the window never reach the output
      holdCount <= 2'h0;
      filtOut   <= rawIn;
    end else begin
      holdCount <= holdCount + 2'h1;
    end
  end

endmodule : apfs_noise_filter

// [hw/apfs_port_function_select.sv]
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module apfs_port_function_select #(
  parameter int ONESHOT_LEN = apfs_pkg::ONESHOT_CYCLES
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [3:0]             regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [31:0]            regRdData,
  // Motion status from the axis
  input  wire apfs_pkg::apfs_motion_t motionStatus,
  // Port pins
  input  wire logic [7:0]             portPinIn,
  output logic      [7:0]             portPinOut,
  output logic      [7:0]             portPinOe,
  // Encoder pins and conditioned result
  input  wire apfs_pkg::apfs_encoder_t encoderPins,
  output apfs_pkg::apfs_encoder_t      encoderClean
);

  localparam int NP = apfs_pkg::NUM_PINS;

  logic [31:0]              environment_two_port_config;
  logic [NP-1:0]            outValue;
  logic [1:0]               shotActive;
  logic [1:0][24:0]         shotCount;
  logic [NP-1:0]            pinSync1;
  logic [NP-1:0]            pinSync2;
  apfs_pkg::apfs_encoder_t  encSync1;
  apfs_pkg::apfs_encoder_t  encSync2;
  apfs_pkg::apfs_encoder_t  encFilt;
  logic [NP-1:0]            next_pinOut;
  logic [NP-1:0]            next_pinOe;
  logic [NP-1:0]            flagLevel;
  logic                     filterOn;

  function automatic logic [1:0] pinFunc(input logic [31:0] env, input int idx);
    pinFunc = env[idx*apfs_pkg::FUNC_WIDTH +: apfs_pkg::FUNC_WIDTH];
  endfunction : pinFunc

  assign filterOn = environment_two_port_config[apfs_pkg::ENC_FILT_BIT];
  assign flagLevel = {motionStatus.compareMatch, motionStatus.constSpeed,
                      motionStatus.decel, motionStatus.accel};

  // Configuration and output value registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      environment_two_port_config <= apfs_pkg::ENV2_RESET;
    end else if (regWrite && regAddr == apfs_pkg::ADDR_ENV2) begin
      // Bits above the implemented fields read as zero
      environment_two_port_config <= {13'h0000, regWrData[apfs_pkg::ENV2_IMPL_MSB:0]};
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      outValue <= apfs_pkg::OUTVAL_RESET;
    end else if (regWrite && regAddr == apfs_pkg::ADDR_OUTVAL) begin
      outValue <= regWrData[NP-1:0];
    end
  end

  // One-shot timers for pins zero and one, retriggered by a write of 1
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_shot
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          shotActive[s] <= 1'b0;
          shotCount[s]  <= 25'h0000000;
        end else if (regWrite && regAddr == apfs_pkg::ADDR_ONESHOT && regWrData[s]) begin
          shotActive[s] <= 1'b1;
          shotCount[s]  <= 25'(ONESHOT_LEN - 1);
        end else if (shotActive[s]) begin
          if (shotCount[s] == 25'h0000000) begin
            shotActive[s] <= 1'b0;
          end else begin
            shotCount[s] <= shotCount[s] - 25'h0000001;
          end
        end
      end
    end
  endgenerate

  // Input synchronisers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinSync1 <= 8'h00;
      pinSync2 <= 8'h00;
      encSync1 <= 3'h0;
      encSync2 <= 3'h0;
    end else begin
      pinSync1 <= portPinIn;
      pinSync2 <= pinSync1;
      encSync1 <= encoderPins;
      encSync2 <= encSync1;
    end
  end

  // Encoder filter, one per line
  genvar e;
  generate
    for (e = 0; e < 3; e++) begin : g_filt
      apfs_noise_filter #(
        .FILT_CYCLES (apfs_pkg::FILTER_CYCLES)
      ) u_filt (
        .clock   (clock),
        .sys_rst (sys_rst),
        .enable  (filterOn),
        .rawIn   (encSync2[e]),
        .filtOut (encFilt[e])
      );
    end
  endgenerate

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      encoderClean <= 3'h0;
    end else begin
      encoderClean <= encFilt;
    end
  end

  // Pin function decode
  always_comb begin
    logic [1:0] fn;
    logic       pol;
    fn          = 2'h0;
    pol         = 1'b0;
    next_pinOut = 8'h00;
    next_pinOe  = 8'h00;
    // Pins zero and one: 01 differs between them, polarity from its own bit
    for (int p = 0; p < 2; p++) begin
      fn  = pinFunc(environment_two_port_config, p);
      pol = environment_two_port_config[apfs_pkg::POL_ZERO_BIT + p];
      case (fn)
        apfs_pkg::FN_INPUT: begin
          next_pinOe[p] = 1'b0;
        end
        apfs_pkg::FN_OUTPUT: begin
          // Pin zero has no output mode, code 01 is still an input
          next_pinOe[p]  = (p == 1);
          next_pinOut[p] = (p == 1) ? outValue[p] : 1'b0;
        end
        apfs_pkg::FN_FLAGLO: begin
          next_pinOe[p]  = 1'b1;
          next_pinOut[p] = ~(flagLevel[p] ^ pol);
        end
        apfs_pkg::FN_FLAGHI: begin
          next_pinOe[p]  = 1'b1;
          next_pinOut[p] = ~(shotActive[p] ^ pol);
        end
        default: begin
          next_pinOe[p] = 1'b0;
        end
      endcase
    end
    for (int p = 2; p < NP; p++) begin
      fn = pinFunc(environment_two_port_config, p);
      case (fn)
        apfs_pkg::FN_INPUT: begin
          next_pinOe[p] = 1'b0;
        end
        apfs_pkg::FN_OUTPUT: begin
          next_pinOe[p]  = 1'b1;
          next_pinOut[p] = outValue[p];
        end
        apfs_pkg::FN_FLAGLO: begin
          next_pinOe[p]  = 1'b1;
          next_pinOut[p] = ~flagLevel[p];
        end
        apfs_pkg::FN_FLAGHI: begin
          next_pinOe[p]  = 1'b1;
          next_pinOut[p] = flagLevel[p];
        end
        default: begin
          next_pinOe[p] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      portPinOut <= 8'h00;
      portPinOe  <= 8'h00;
    end else begin
      portPinOut <= next_pinOut;
      portPinOe  <= next_pinOe;
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRead) begin
      case (regAddr)
        apfs_pkg::ADDR_ENV2:    regRdData <= environment_two_port_config;
        apfs_pkg::ADDR_OUTVAL:  regRdData <= {24'h000000, outValue};
        apfs_pkg::ADDR_ONESHOT: regRdData <= {30'h00000000, shotActive};
        apfs_pkg::ADDR_PINS:    regRdData <= {24'h000000, pinSync2};
        apfs_pkg::ADDR_ENC:     regRdData <= {29'h00000000, encFilt};
        default:                regRdData <= 32'h0000_0000;
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // Checks
  pin0_input_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[1] == 1'b0) |=> !portPinOe[0])
    else $error("pin zero driven in input mode");

  accel_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[1:0] == 2'h2)
      |=> portPinOe[0] && (portPinOut[0] == ~($past(motionStatus.accel) ^
          $past(environment_two_port_config[16]))))
    else $error("pin zero not showing acceleration flag");

  shot_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == apfs_pkg::ADDR_ONESHOT && regWrData[0])
      |=> shotActive[0] && shotCount[0] == 25'(ONESHOT_LEN - 1))
    else $error("one-shot not loaded with its length");

  shot_pin1_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[3:2] == 2'h3)
      |=> portPinOe[1] && (portPinOut[1] == ~($past(shotActive[1]) ^
          $past(environment_two_port_config[17]))))
    else $error("pin one one-shot level wrong");

  pin1_output_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[3:2] == 2'h1)
      |=> portPinOe[1] && portPinOut[1] == $past(outValue[1]))
    else $error("pin one output value wrong");

  decel_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[3:2] == 2'h2)
      |=> portPinOut[1] == ~($past(motionStatus.decel) ^
          $past(environment_two_port_config[17])))
    else $error("pin one not showing deceleration flag");

  speed_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[5:4] == 2'h2)
      |=> portPinOut[2] == !$past(motionStatus.constSpeed))
    else $error("constant-speed flag polarity wrong");

  cmp_one_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[7:6] == 2'h2)
      |=> portPinOe[3] && portPinOut[3] == !$past(motionStatus.compareMatch[0]))
    else $error("comparator one output wrong");

  cmp_two_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[9:8] == 2'h3)
      |=> portPinOe[4] && portPinOut[4] == $past(motionStatus.compareMatch[1]))
    else $error("comparator two output wrong");

  cmp_three_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[11:10] == 2'h2)
      |=> portPinOe[5] && portPinOut[5] == !$past(motionStatus.compareMatch[2]))
    else $error("comparator three output wrong");

  cmp_four_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[13:12] == 2'h3)
      |=> portPinOe[6] && portPinOut[6] == $past(motionStatus.compareMatch[3]))
    else $error("comparator four output wrong");

  cmp_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    (environment_two_port_config[15:14] == 2'h3)
      |=> portPinOe[7] && portPinOut[7] == $past(motionStatus.compareMatch[4]))
    else $error("comparator five output wrong");

  filter_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    !filterOn |=> encFilt == $past(encSync2))
    else $error("encoder path delayed with filter off");

  enc_filter_on_a: assert property (@(posedge clock) disable iff (sys_rst)
    filterOn && $changed(encSync2.phaseA) |=> encFilt.phaseA == $past(encFilt.phaseA))
    else $error("encoder edge passed filter at once");

  outval_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(regWrite && regAddr == apfs_pkg::ADDR_OUTVAL) |=> $stable(outValue))
    else $error("output value changed without a write");

endmodule : apfs_port_function_select

// [testbench/apfs_equipment_model.sv]
`timescale 1ns/10ps
// Machine side of the port pins; it yields wherever the block drives
module apfs_equipment_model (
  // Block side
  input  wire logic [7:0] portPinOut,
  input  wire logic [7:0] portPinOe,
  // Equipment side
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinLevel
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLevel[i] = portPinOe[i] ? portPinOut[i] : extLevel[i];
    end
  end
endmodule : apfs_equipment_model

// [testbench/test_apfs_port_function_select.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module test_apfs_port_function_select;
  localparam int SHOT = 20;
  logic                    clock, sys_rst, regWrite, regRead;
  logic [3:0]              regAddr;
  logic [31:0]             regWrData, regRdData, rnd, env, rd;
  apfs_pkg::apfs_motion_t  motionStatus;
  apfs_pkg::apfs_encoder_t encoderPins, encoderClean;
  logic [7:0]              portPinIn, portPinOut, portPinOe, extLevel, ov;
  logic [15:0]             pe;
  int                      n_mismatch, check_count, cnt;

  apfs_port_function_select #(.ONESHOT_LEN(SHOT)) dut (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .motionStatus(motionStatus), .portPinIn(portPinIn), .portPinOut(portPinOut),
    .portPinOe(portPinOe), .encoderPins(encoderPins), .encoderClean(encoderClean));
  apfs_equipment_model eq (.portPinOut(portPinOut), .portPinOe(portPinOe),
    .extLevel(extLevel), .pinLevel(portPinIn));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Enables over levels, with no one-shot running
  function automatic logic [15:0] pinExp(input logic [31:0] e,
      input apfs_pkg::apfs_motion_t m, input logic [7:0] v);
    logic [7:0] oe, out, flag;
    logic [1:0] fn;
    flag = {m.compareMatch, m.constSpeed, m.decel, m.accel};
    for (int i = 0; i < 8; i++) begin
      fn = e[2*i +: 2];
      oe[i] = (fn != 2'h0) && !(i == 0 && fn == 2'h1);
      if (fn == 2'h1) out[i] = v[i];
      else if (i < 2) out[i] = ((fn == 2'h2) & flag[i]) ^ ~e[16 + i];
      else out[i] = flag[i] ^ (fn == 2'h2);
    end
    return {oe, out};
  endfunction : pinExp

  task automatic regWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask : regRd

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    motionStatus = '0;
    encoderPins = '0;
    extLevel = 8'h00;
    rnd = 32'he18a;
    n_mismatch = 0;
    check_count = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    `CHK("oe after reset", 8'h00, portPinOe)
    regRd(apfs_pkg::ADDR_ENV2, rd);
    `CHK("env reset", apfs_pkg::ENV2_RESET, rd)
    regRd(apfs_pkg::ADDR_OUTVAL, rd);
    `CHK("outval reset", {24'h0, apfs_pkg::OUTVAL_RESET}, rd)
    regWr(4'hf, 32'hffff_ffff);
    regRd(4'hf, rd);
    `CHK("unmapped read", 32'h0, rd)
    // Codes 01, 10 and 11 on every pin first, then random mixes
    for (int k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      env = (k == 0) ? 32'h0000_5555 : (k == 1) ? 32'hfff8_aaaa :
            (k == 2) ? 32'h0003_ffff : rnd;
      regWr(apfs_pkg::ADDR_ENV2, env);
      rnd = lfsr(rnd);
      ov = rnd[15:8];
      regWr(apfs_pkg::ADDR_OUTVAL, {24'h0, ov});
      motionStatus <= apfs_pkg::apfs_motion_t'(rnd[7:0]);
      extLevel <= rnd[23:16];
      repeat (3) @(posedge clock);
      @(negedge clock);
      pe = pinExp(env, motionStatus, ov);
      `CHK("pin enable", pe[15:8], portPinOe)
      `CHK("pin level", pe[7:0] & pe[15:8], portPinOut & pe[15:8])
      regRd(apfs_pkg::ADDR_PINS, rd);
      `CHK("pin inputs", {24'h0, (pe[7:0] & pe[15:8]) | (extLevel & ~pe[15:8])}, rd)
      regRd(apfs_pkg::ADDR_ENV2, rd);
      `CHK("env readback", env & 32'h0007_ffff, rd)
    end
    // One-shot on pin zero active high, on pin one active low
    for (int j = 0; j < 2; j++) begin
      regWr(apfs_pkg::ADDR_ENV2, j ? 32'h0000_000c : 32'h0001_0003);
      regWr(apfs_pkg::ADDR_ONESHOT, j ? 32'h2 : 32'h1);
      cnt = 0;
      for (int k = 0; k < 4 * SHOT; k++) begin
        @(negedge clock);
        cnt = cnt + (portPinOut[j] === (j ? 1'b0 : 1'b1));
      end
      `CHK("shot length", SHOT, cnt)
    end
    // A two-cycle glitch must not pass the filter, a held level must
    regWr(apfs_pkg::ADDR_ENV2, 32'h0004_0000);
    encoderPins <= apfs_pkg::apfs_encoder_t'(3'b111);
    repeat (2) @(posedge clock);
    encoderPins <= '0;
    cnt = 0;
    repeat (10) begin
      @(negedge clock);
      cnt = cnt + (encoderClean !== 3'b000);
    end
    `CHK("glitch passed", 0, cnt)
    @(posedge clock);
    encoderPins <= apfs_pkg::apfs_encoder_t'(3'b101);
    repeat (8) @(posedge clock);
    @(negedge clock);
    `CHK("encoder held", 3'b101, encoderClean)
    stop_test();
  end
endmodule : test_apfs_port_function_select
